// [rtl/ems_pkg.sv]
package ems_pkg;

    // Register offsets are coprocessor register numbers; byte address is four times the index.
    localparam logic [7:0]  CACHE_LOCK_STACK_IDX      = 8'h07;
    localparam logic [7:0]  FAULT_VIRTUAL_ADDRESS_IDX = 8'h08;
    localparam logic [7:0]  MODE_STACK_IDX            = 8'h0C;
    localparam logic [11:0] CACHE_LOCK_STACK_ADDR     = {2'h0, CACHE_LOCK_STACK_IDX, 2'h0};
    localparam logic [11:0] FAULT_VIRTUAL_ADDRESS_ADDR = {2'h0, FAULT_VIRTUAL_ADDRESS_IDX, 2'h0};
    localparam logic [11:0] MODE_STACK_ADDR           = {2'h0, MODE_STACK_IDX, 2'h0};

    localparam int LOCK_LSB = 8;
    localparam int LOCK_MSB = 13;
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 5;

    localparam logic [5:0]  LOCK_RESET  = 6'h00;
    localparam logic [5:0]  MODE_RESET  = 6'h00;
    localparam logic [31:0] FVA_RESET   = 32'h00000000;
    localparam logic        KERNEL_MODE = 1'b0;
    localparam logic        IRQ_MASKED  = 1'b0;

    typedef enum logic [2:0] {
        EMS_EXC_OTHER,
        EMS_EXC_LOAD_ADDR_ERR,
        EMS_EXC_STORE_ADDR_ERR,
        EMS_EXC_TLB_REFILL,
        EMS_EXC_TLB_MODIFIED,
        EMS_EXC_UTLB_REFILL,
        EMS_EXC_BUS_ERROR
    } ems_exc_e;

    // Exception entry from the pipeline.
    typedef struct packed {
        logic        take;
        ems_exc_e    kind;
        logic [31:0] vaddr;
    } ems_exc_s;

    // Three-level stack, one slot each: old, previous, current.
    typedef struct packed {
        logic old_bit;
        logic prev_bit;
        logic cur_bit;
    } ems_stack_s;

endpackage : ems_pkg

// [rtl/ems_stack3.sv]
`timescale 1ns/1ps
`default_nettype none
module ems_stack3 (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              clk_en,
    input  wire logic              push,
    input  wire logic              pop,
    input  wire logic              sw_write,
    input  var  ems_pkg::ems_stack_s sw_value,
    output var  ems_pkg::ems_stack_s stack
);

    typedef struct packed {
        ems_pkg::ems_stack_s stk;
    } ems_st3_state_s;

    ems_st3_state_s state;
    ems_st3_state_s next_state;

    // Push wins over pop and over a software write in the same cycle, since the exception
    // must never be lost.
    always_comb begin
        next_state = state;
        if (push) begin
            next_state.stk.old_bit  = state.stk.prev_bit;
            next_state.stk.prev_bit = state.stk.cur_bit;
            next_state.stk.cur_bit  = 1'b0;
        end else if (pop) begin
            next_state.stk.cur_bit  = state.stk.prev_bit;
            next_state.stk.prev_bit = state.stk.old_bit;
        end else if (sw_write) begin
            next_state.stk = sw_value;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= '0;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign stack = state.stk;

endmodule : ems_stack3
`default_nettype wire

// [rtl/ems_exception_mode_stack.sv]
// Operation
// - Lock register bits 13..8, read/write
// - Other lock register bits read zero
// - Reset clears all six lock bits
// - Exception pushes data lock stack, clears current
// - Exception pushes instruction lock stack, clears current
// - Exception pushes mode stacks: kernel, masked
// - Restore pops mode and interrupt stacks
// - Restore pops both lock stacks
// - Lock outputs gated by lock cache presence
// - Address errors capture faulting virtual address
// - Translation failures capture failing virtual address
// - Fault address register is read-only
// - Bus error leaves fault address alone
// - Mode 0 kernel, enable 1 enabled
`timescale 1ns/1ps
`default_nettype none
module ems_exception_mode_stack #(
    parameter bit HAS_LOCK_CACHE = 1'b1
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             clk_en,
    input  var  ems_pkg::ems_exc_s exc_in,
    input  wire logic             restore_from_exception_op,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    output logic                  priv_mode_cur,
    output logic                  irq_enable_cur,
    output logic                  data_lock_active,
    output logic                  instr_lock_active
);

    ////////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [31:0] fault_virtual_address;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        mode_out;
        logic        irq_out;
        logic        dlock_out;
        logic        ilock_out;
    } ems_top_state_s;

    ems_top_state_s state;
    ems_top_state_s next_state;

    ems_pkg::ems_stack_s priv_stack;
    ems_pkg::ems_stack_s irq_stack;
    ems_pkg::ems_stack_s ilock_stack;
    ems_pkg::ems_stack_s dlock_stack;

    logic push;
    logic pop;
    logic access;
    logic wr_lock;
    logic wr_mode;
    logic [31:0] lock_word;
    logic [31:0] mode_word;
    logic [31:0] next_mode_view;
    logic [31:0] next_lock_view;

    // A restore in the same cycle as an exception entry is dropped: the exception
    // squashes the instruction that would have issued it.
    assign push   = exc_in.take;
    assign pop    = restore_from_exception_op & ~exc_in.take;
    assign access = psel & penable & ~state.ready;

    // Software writes land only when the byte lane holding the stack bits is enabled: pstrb[1] for the lock register, pstrb[0] for the mode stack.
    assign wr_lock = access & pwrite & pstrb[1] & (paddr == ems_pkg::CACHE_LOCK_STACK_ADDR);
    assign wr_mode = access & pwrite & pstrb[0] & (paddr == ems_pkg::MODE_STACK_ADDR);

    ////////////////////////////////////////////////////////////////////////////////

    ems_stack3 u_priv (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .push     (push),
        .pop      (pop),
        .sw_write (wr_mode),
        .sw_value ({pwdata[5], pwdata[3], pwdata[1]}),
        .stack    (priv_stack)
    );

    ems_stack3 u_irq (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .push     (push),
        .pop      (pop),
        .sw_write (wr_mode),
        .sw_value ({pwdata[4], pwdata[2], pwdata[0]}),
        .stack    (irq_stack)
    );

    ems_stack3 u_ilock (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .push     (push),
        .pop      (pop),
        .sw_write (wr_lock),
        .sw_value ({pwdata[13], pwdata[11], pwdata[9]}),
        .stack    (ilock_stack)
    );

    ems_stack3 u_dlock (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .push     (push),
        .pop      (pop),
        .sw_write (wr_lock),
        .sw_value ({pwdata[12], pwdata[10], pwdata[8]}),
        .stack    (dlock_stack)
    );

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        lock_word = 32'h00000000;
        lock_word[ems_pkg::LOCK_MSB:ems_pkg::LOCK_LSB] = {ilock_stack.old_bit, dlock_stack.old_bit,
                                                        ilock_stack.prev_bit, dlock_stack.prev_bit,
                                                        ilock_stack.cur_bit, dlock_stack.cur_bit};
        mode_word = 32'h00000000;
        mode_word[ems_pkg::MODE_MSB:ems_pkg::MODE_LSB] = {priv_stack.old_bit, irq_stack.old_bit,
                                                        priv_stack.prev_bit, irq_stack.prev_bit,
                                                        priv_stack.cur_bit, irq_stack.cur_bit};
    end

    // Outputs look ahead to the stacks' next value so they stay in step with the stack flops.
    always_comb begin
        next_lock_view = lock_word;
        next_mode_view = mode_word;
        if (push) begin
            next_lock_view[13:8] = {lock_word[11:8], 2'h0};
            next_mode_view[5:0]  = {mode_word[3:0], 2'h0};
        end else if (pop) begin
            next_lock_view[11:8] = lock_word[13:10];
            next_mode_view[3:0]  = mode_word[5:2];
        end else begin
            if (wr_lock) begin
                next_lock_view[13:8] = pwdata[13:8];
            end
            if (wr_mode) begin
                next_mode_view[5:0] = pwdata[5:0];
            end
        end
    end

    always_comb begin
        next_state = state;
        next_state.ready  = access;
        next_state.slverr = 1'b0;
        next_state.rdata  = 32'h00000000;
        if (access && !pwrite) begin
            case (paddr)
                ems_pkg::CACHE_LOCK_STACK_ADDR:      next_state.rdata = lock_word;
                ems_pkg::FAULT_VIRTUAL_ADDRESS_ADDR: next_state.rdata = state.fault_virtual_address;
                ems_pkg::MODE_STACK_ADDR:            next_state.rdata = mode_word;
                default:                             next_state.slverr = 1'b1;
            endcase
        end else if (access) begin
            // The fault address accepts the write cycle but keeps its contents.
            case (paddr)
                ems_pkg::CACHE_LOCK_STACK_ADDR,
                ems_pkg::FAULT_VIRTUAL_ADDRESS_ADDR,
                ems_pkg::MODE_STACK_ADDR:            next_state.slverr = 1'b0;
                default:                             next_state.slverr = 1'b1;
            endcase
        end
        if (exc_in.take) begin
            case (exc_in.kind)
                ems_pkg::EMS_EXC_LOAD_ADDR_ERR,
                ems_pkg::EMS_EXC_STORE_ADDR_ERR: next_state.fault_virtual_address = exc_in.vaddr;
                ems_pkg::EMS_EXC_TLB_REFILL,
                ems_pkg::EMS_EXC_TLB_MODIFIED,
                ems_pkg::EMS_EXC_UTLB_REFILL:    next_state.fault_virtual_address = exc_in.vaddr;
                default: next_state.fault_virtual_address = state.fault_virtual_address;
            endcase
        end
        next_state.mode_out  = next_mode_view[1];
        next_state.irq_out   = next_mode_view[0];
        next_state.ilock_out = HAS_LOCK_CACHE & next_lock_view[9];
        next_state.dlock_out = HAS_LOCK_CACHE & next_lock_view[8];
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= '0;
            state.fault_virtual_address <= ems_pkg::FVA_RESET;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign prdata            = state.rdata;
    assign pready            = state.ready;
    assign pslverr           = state.slverr;
    assign priv_mode_cur     = state.mode_out;
    assign irq_enable_cur    = state.irq_out;
    assign data_lock_active  = state.dlock_out;
    assign instr_lock_active = state.ilock_out;

    ////////////////////////////////////////////////////////////////////////////////

    // The checks look at the stack flops themselves, so a fault in the look-ahead output
    // path and a fault in the stacks are reported apart.

    chk_push_kernel_mode: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && exc_in.take
        |=> priv_stack.cur_bit == ems_pkg::KERNEL_MODE
            && irq_stack.cur_bit == ems_pkg::IRQ_MASKED)
        else $error("exception entry did not enter kernel mode masked");

    chk_push_mode_shift: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && exc_in.take
        |=> priv_stack.prev_bit == $past(priv_stack.cur_bit)
            && irq_stack.old_bit == $past(irq_stack.prev_bit))
        else $error("mode stack shift wrong on exception");

    chk_push_mode_rest: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && exc_in.take
        |=> priv_stack.old_bit == $past(priv_stack.prev_bit)
            && irq_stack.prev_bit == $past(irq_stack.cur_bit))
        else $error("mode stack shift incomplete on exception");

    chk_push_dlock: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && exc_in.take
        |=> !dlock_stack.cur_bit
            && dlock_stack.prev_bit == $past(dlock_stack.cur_bit)
            && dlock_stack.old_bit == $past(dlock_stack.prev_bit))
        else $error("data lock stack push wrong");

    chk_push_ilock: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && exc_in.take
        |=> !ilock_stack.cur_bit
            && ilock_stack.prev_bit == $past(ilock_stack.cur_bit)
            && ilock_stack.old_bit == $past(ilock_stack.prev_bit))
        else $error("instruction lock stack push wrong");

    chk_restore_squashed: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && exc_in.take && restore_from_exception_op
        |=> priv_stack.prev_bit == $past(priv_stack.cur_bit)
            && !priv_stack.cur_bit)
        else $error("restore not dropped under exception entry");

    chk_pop_mode: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && pop
        |=> priv_stack.cur_bit == $past(priv_stack.prev_bit)
            && irq_stack.prev_bit == $past(irq_stack.old_bit)
            && $stable(irq_stack.old_bit))
        else $error("mode stack restore wrong");

    chk_pop_mode_rest: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && pop
        |=> irq_stack.cur_bit == $past(irq_stack.prev_bit)
            && priv_stack.prev_bit == $past(priv_stack.old_bit)
            && $stable(priv_stack.old_bit))
        else $error("mode stack restore incomplete");

    chk_pop_lock: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && pop
        |=> dlock_stack.cur_bit == $past(dlock_stack.prev_bit)
            && ilock_stack.prev_bit == $past(ilock_stack.old_bit)
            && $stable(ilock_stack.old_bit))
        else $error("lock stack restore wrong");

    chk_pop_lock_rest: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && pop
        |=> ilock_stack.cur_bit == $past(ilock_stack.prev_bit)
            && dlock_stack.prev_bit == $past(dlock_stack.old_bit)
            && $stable(dlock_stack.old_bit))
        else $error("lock stack restore incomplete");

    chk_reset_lock_clear: assert property (@(posedge ref_clk)
        reset
        |=> lock_word == 32'h00000000
            && mode_word == 32'h00000000
            && state.fault_virtual_address == ems_pkg::FVA_RESET)
        else $error("stacks not cleared by reset");

    chk_fva_capture: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && exc_in.take && exc_in.kind inside {ems_pkg::EMS_EXC_LOAD_ADDR_ERR, ems_pkg::EMS_EXC_STORE_ADDR_ERR}
        |=> state.fault_virtual_address == $past(exc_in.vaddr))
        else $error("address error did not capture fault address");

    chk_fva_tlb: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && exc_in.take && exc_in.kind inside {ems_pkg::EMS_EXC_TLB_REFILL, ems_pkg::EMS_EXC_TLB_MODIFIED,
                                                     ems_pkg::EMS_EXC_UTLB_REFILL}
        |=> state.fault_virtual_address == $past(exc_in.vaddr))
        else $error("translation fault did not capture fault address");

    chk_fva_hold: assert property (@(posedge ref_clk) disable iff (reset)
        !(exc_in.take && exc_in.kind inside {ems_pkg::EMS_EXC_LOAD_ADDR_ERR, ems_pkg::EMS_EXC_STORE_ADDR_ERR,
          ems_pkg::EMS_EXC_TLB_REFILL, ems_pkg::EMS_EXC_TLB_MODIFIED, ems_pkg::EMS_EXC_UTLB_REFILL})
        |=> $stable(state.fault_virtual_address))
        else $error("fault address changed without a capturing exception");

    chk_fva_sw_write: assert property (@(posedge ref_clk) disable iff (reset)
        access && pwrite && paddr == ems_pkg::FAULT_VIRTUAL_ADDRESS_ADDR
        && !exc_in.take
        |=> $stable(state.fault_virtual_address))
        else $error("software write changed the fault address");

    chk_lock_reserved: assert property (@(posedge ref_clk) disable iff (reset)
        state.ready && !pwrite && paddr == ems_pkg::CACHE_LOCK_STACK_ADDR
        |-> prdata[31:14] == 18'h00000
            && prdata[7:0] == 8'h00)
        else $error("reserved lock bits read nonzero");

    chk_lock_write: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && wr_lock && !push && !pop
        |=> lock_word[13:8] == $past(pwdata[13:8]))
        else $error("lock register write not stored");

    chk_mode_write: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && wr_mode && !push && !pop
        |=> mode_word[5:0] == $past(pwdata[5:0]))
        else $error("mode stack write not stored");

    chk_lock_gate: assert property (@(posedge ref_clk) disable iff (reset)
        data_lock_active == (HAS_LOCK_CACHE && dlock_stack.cur_bit)
        && instr_lock_active == (HAS_LOCK_CACHE && ilock_stack.cur_bit))
        else $error("lock output does not follow current lock bit");

    chk_mode_track: assert property (@(posedge ref_clk) disable iff (reset)
        priv_mode_cur == priv_stack.cur_bit
        && irq_enable_cur == irq_stack.cur_bit)
        else $error("mode outputs out of step with mode stack");

    chk_enable_freeze: assert property (@(posedge ref_clk) disable iff (reset)
        !clk_en
        |=> $stable(lock_word)
            && $stable(mode_word)
            && $stable(state.fault_virtual_address))
        else $error("state moved while clock enable was low");

endmodule : ems_exception_mode_stack
`default_nettype wire

// [tb/ems_pipe_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ems_pipe_model (
    input  wire logic              ref_clk,
    output var  ems_pkg::ems_exc_s exc_in,
    output var  logic              restore_from_exception_op
);
    initial begin
        exc_in = '0;
        restore_from_exception_op = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Between pulses the address is inverted so that a stale value can never pass as captured.
    task automatic raise_exception(input ems_pkg::ems_exc_e kind, input logic [31:0] vaddr);
        @(posedge ref_clk);
        exc_in.take  <= 1'b1;
        exc_in.kind  <= kind;
        exc_in.vaddr <= vaddr;
        @(posedge ref_clk);
        exc_in.take  <= 1'b0;
        exc_in.vaddr <= ~vaddr;
    endtask : raise_exception

    task automatic restore_op();
        @(posedge ref_clk);
        restore_from_exception_op <= 1'b1;
        @(posedge ref_clk);
        restore_from_exception_op <= 1'b0;
    endtask : restore_op
endmodule : ems_pipe_model
`default_nettype wire

// [tb/test_exception_mode_stack_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module test_exception_mode_stack_unit;
    logic              ref_clk = 1'b0;
    logic              reset = 1'b1;
    logic              clk_en = 1'b1;
    ems_pkg::ems_exc_s exc_in;
    logic              restore_from_exception_op;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [11:0]       paddr = 12'h000;
    logic [31:0]       pwdata = 32'h00000000;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              priv_mode_cur;
    logic              irq_enable_cur;
    logic              data_lock_active;
    logic              instr_lock_active;
    logic              dlock_nolock;
    logic              ilock_nolock;
    int                mismatches = 0;
    int                cmp_count = 0;
    int                cycles = 0;
    logic [31:0]       seed = 32'hCB65;
    logic [5:0]        exp_mode = 6'h00;
    logic [5:0]        exp_lock = 6'h00;
    logic [31:0]       exp_fva = 32'h00000000;

    always #20 ref_clk = ~ref_clk;

    ems_exception_mode_stack u_ems_exception_mode_stack (
        .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .exc_in(exc_in),
        .restore_from_exception_op(restore_from_exception_op), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .priv_mode_cur(priv_mode_cur),
        .irq_enable_cur(irq_enable_cur), .data_lock_active(data_lock_active),
        .instr_lock_active(instr_lock_active)
    );

    // A second copy without a lock cache shows the lock outputs held off.
    ems_exception_mode_stack #(.HAS_LOCK_CACHE(1'b0)) u_ems_exception_mode_stack_nolock (
        .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .exc_in(exc_in),
        .restore_from_exception_op(restore_from_exception_op), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(), .pready(), .pslverr(),
        .priv_mode_cur(), .irq_enable_cur(), .data_lock_active(dlock_nolock),
        .instr_lock_active(ilock_nolock)
    );

    ems_pipe_model u_ems_pipe_model (
        .ref_clk(ref_clk), .exc_in(exc_in), .restore_from_exception_op(restore_from_exception_op)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Both stacks hold {old, prev, cur} pairs, so one push and one pop serve them.
    function automatic logic [5:0] push(input logic [5:0] s);
        return {s[3:0], 2'b00};
    endfunction : push

    function automatic logic [5:0] pop(input logic [5:0] s);
        return {s[5:4], s[5:2]};
    endfunction : pop

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // The request stands until pready is sampled high at a rising edge; the answer is taken at
    // that same edge and only then is the request released. Only the bench timeout ends a wait.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic check_outputs();
        check("outputs", {28'h0, priv_mode_cur, irq_enable_cur, data_lock_active, instr_lock_active},
              {28'h0, exp_mode[1], exp_mode[0], exp_lock[0], exp_lock[1]});
        check("lock_gated", {30'h0, dlock_nolock, ilock_nolock}, 32'h0);
    endtask : check_outputs

    task automatic check_all();
        logic [31:0] rd;
        logic        e;
        apb(1'b0, ems_pkg::CACHE_LOCK_STACK_ADDR, 32'h0, rd, e);
        check("lock_stack", rd, {18'h0, exp_lock, 8'h00});
        apb(1'b0, ems_pkg::MODE_STACK_ADDR, 32'h0, rd, e);
        check("mode_stack", {26'h0, rd[5:0]}, {26'h0, exp_mode});
        apb(1'b0, ems_pkg::FAULT_VIRTUAL_ADDRESS_ADDR, 32'h0, rd, e);
        check("fault_addr", rd, exp_fva);
        check_outputs();
    endtask : check_all

    task automatic do_exception(input ems_pkg::ems_exc_e kind, input logic [31:0] va);
        u_ems_pipe_model.raise_exception(kind, va);
        exp_mode = push(exp_mode);
        exp_lock = push(exp_lock);
        if (kind inside {ems_pkg::EMS_EXC_LOAD_ADDR_ERR, ems_pkg::EMS_EXC_STORE_ADDR_ERR,
                         ems_pkg::EMS_EXC_TLB_REFILL, ems_pkg::EMS_EXC_TLB_MODIFIED,
                         ems_pkg::EMS_EXC_UTLB_REFILL})
            exp_fva = va;
        #1 check_outputs();
    endtask : do_exception

    task automatic do_restore();
        u_ems_pipe_model.restore_op();
        exp_mode = pop(exp_mode);
        exp_lock = pop(exp_lock);
        #1 check_outputs();
    endtask : do_restore

    task automatic write_stacks(input logic [31:0] lk, input logic [31:0] md);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, ems_pkg::CACHE_LOCK_STACK_ADDR, lk, rd, e);
        apb(1'b1, ems_pkg::MODE_STACK_ADDR, md, rd, e);
        exp_lock = lk[13:8];
        exp_mode = md[5:0];
    endtask : write_stacks

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    initial begin
        logic [31:0] r;
        logic [31:0] rd;
        logic        e;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        check_all();
        write_stacks(32'hFFFFFFFF, 32'h0000003F);
        check_all();
        for (int k = 0; k < 7; k++) begin
            write_stacks(32'h00003F00, 32'h0000003F);
            do_exception(ems_pkg::ems_exc_e'(k), rnd());
            do_exception(ems_pkg::ems_exc_e'(6 - k), rnd());
            check_all();
            do_restore();
            do_restore();
            check_all();
        end
        apb(1'b1, ems_pkg::FAULT_VIRTUAL_ADDRESS_ADDR, ~exp_fva, rd, e);
        check("fault_write_err", {31'h0, e}, 32'h0);
        check_all();
        apb(1'b0, 12'hFFC, 32'h0, rd, e);
        check("unmapped_err", {31'h0, e}, 32'h1);
        check("unmapped_data", rd, 32'h0);
        // A restore in the same cycle as an exception entry is dropped.
        r = rnd();
        fork
            u_ems_pipe_model.raise_exception(ems_pkg::EMS_EXC_TLB_MODIFIED, r);
            u_ems_pipe_model.restore_op();
        join
        exp_mode = push(exp_mode);
        exp_lock = push(exp_lock);
        exp_fva = r;
        check_all();
        // An exception while the clock enable is low must leave every stack alone.
        @(posedge ref_clk);
        clk_en <= 1'b0;
        u_ems_pipe_model.raise_exception(ems_pkg::EMS_EXC_LOAD_ADDR_ERR, ~exp_fva);
        clk_en <= 1'b1;
        check_all();
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            case (r[1:0])
                2'd0: do_exception(ems_pkg::ems_exc_e'(r[4:2] % 7), rnd());
                2'd1: do_restore();
                2'd2: write_stacks(rnd(), rnd());
                default: check_all();
            endcase
        end
        write_stacks(32'h00003F00, 32'h0000003F);
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        exp_lock = 6'h00;
        exp_mode = 6'h00;
        exp_fva = ems_pkg::FVA_RESET;
        check_all();
        print_verdict();
    end
endmodule : test_exception_mode_stack_unit
`default_nettype wire
